//--- verification/cks_sa_mem.sv
`timescale 1ns/1ps
module cks_sa_mem
  import cks_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // Table access
  input  wire logic                sa_wr_en,
  input  wire logic [SA_IDX_W-1:0] sa_wr_idx,
  input  wire logic [SA_W-1:0]     sa_wr_data,
  input  wire logic                sa_rd_en,
  input  wire logic [SA_IDX_W-1:0] sa_rd_idx,
  input  wire logic [3:0]          lat,
  output logic                     sa_rd_valid,
  output logic [SA_W-1:0]          sa_rd_data
);
  // ==========
  // Storage and delayed answer
  logic [SA_W-1:0]     mem [0:(1<<SA_IDX_W)-1];
  logic [SA_IDX_W-1:0] idx_q;
  int                  wait_n;

  initial begin
    mem = '{default: '0};
    sa_rd_valid = 1'b0;
    sa_rd_data = '0;
    idx_q = '0;
    wait_n = -1;
  end

  // Outside an answer the data lines toggle, so a stale entry never passes for a fresh one.
  always @(posedge clk_sys) begin
    sa_rd_valid <= 1'b0;
    if (sa_wr_en) begin
      mem[sa_wr_idx] <= sa_wr_data;
    end
    if (sa_rd_en) begin
      idx_q <= sa_rd_idx;
      wait_n <= lat;
      sa_rd_data <= ~sa_rd_data;
    end else if (wait_n == 0) begin
      sa_rd_valid <= 1'b1;
      sa_rd_data <= mem[idx_q];
      wait_n <= -1;
    end else begin
      sa_rd_data <= ~sa_rd_data;
      if (wait_n > 0) begin
        wait_n <= wait_n - 1;
      end
    end
  end
endmodule // cks_sa_mem

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cks_pkg::*;
  // ==========
  // Signals
  logic                clk_sys, rst_n, key_wr_en, key_wr_sel, rd_en, rd_valid, ctl_valid, ctl_op;
  logic                ctl_key_256, ctl_ready, ctl_rsp_valid, ctl_rsp_ok, sa_wr_en, sa_rd_en, sa_rd_valid;
  logic                pkt_in_valid, pkt_in_ready, pkt_in_crypto, pkt_in_psp, pkt_in_ingress;
  logic                pkt_in_key_256, pkt_out_valid, pkt_out_crypto, pkt_out_drop, st_ready, st_fail;
  logic [2:0]          key_wr_idx, st_err_code;
  logic [3:0]          rd_addr, lat;
  logic [31:0]         key_wr_data, rd_data, pkt_in_spi, r;
  logic [SA_IDX_W-1:0] ctl_sa_idx, sa_wr_idx, sa_rd_idx, pkt_in_sa_idx;
  logic [KW-1:0]       ctl_key, mkey, wkey, skey, ek, ks;
  logic [SA_W-1:0]     sa_wr_data, sa_rd_data, e0;
  logic [CTR_W-1:0]    pkt_in_iv;
  logic [PKT_W-1:0]    pkt_in_data, pkt_out_data, d;
  int                  fail_count, total_checks;

  cks_key_store uut (.*);
  cks_sa_mem sa_mem (.*);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========
  // Helpers
  task automatic chk(input logic [511:0] seen, input logic [511:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    chk(s, 1'b1, "handshake");
  endtask

  function automatic logic [31:0] exp_status(input logic rdy, input logic fl, input logic [2:0] ec);
    return {27'h0, ec, fl, rdy};
  endfunction

  // Reference for the reduced keyed round engine: five rounds of rotate, key and round mix.
  function automatic logic [KW-1:0] ref_core(input logic [KW-1:0] k, input logic [KW-1:0] b);
    logic [KW-1:0] s;
    s = b;
    for (int i = 0; i < ROUNDS; i++) begin
      s = {s[KW-33:0], s[KW-1:KW-32]} ^ k ^ {KEY_WORDS{32'(i)}};
    end
    return s;
  endfunction

  // Requests are held up through reset and the first 20 cycles of the self tests on purpose; they must not be taken.
  task automatic do_reset();
    rst_n <= 1'b0;
    ctl_valid <= 1'b1;
    pkt_in_valid <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk({sa_wr_data, pkt_out_data, rd_data, st_ready}, '0, "outputs under reset");
    rst_n <= 1'b1;
    repeat (20) begin
      @(negedge clk_sys);
      chk({ctl_ready, pkt_in_ready, pkt_out_valid, sa_wr_en, ctl_rsp_valid}, '0, "quiet tests");
    end
    @(posedge clk_sys);
    ctl_valid <= 1'b0;
    pkt_in_valid <= 1'b0;
    @(negedge clk_sys);
    wait_hi(st_ready, 200);
    chk({st_fail, st_err_code}, '0, "no failure");
    $display("test reset done");
  endtask

  task automatic load_keys();
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      key_wr_en <= 1'b1;
      key_wr_sel <= (i >= 8) ? KSEL_WRAP : KSEL_MASTER;
      key_wr_idx <= 3'(i % 8);
      key_wr_data <= (i >= 8) ? wkey[32*(i%8) +: 32] : mkey[32*(i%8) +: 32];
    end
    @(posedge clk_sys);
    key_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    chk({rd_valid, rd_data}, {1'b1, exp}, "status read");
  endtask

  task automatic ctl(input logic op, input logic [SA_IDX_W-1:0] idx, input logic k256);
    @(posedge clk_sys);
    ctl_valid <= 1'b1;
    ctl_op <= op;
    ctl_sa_idx <= idx;
    ctl_key <= skey;
    ctl_key_256 <= k256;
    @(negedge clk_sys);
    wait_hi(ctl_ready, 40);
    @(posedge clk_sys);
    ctl_valid <= 1'b0;
    @(negedge clk_sys);
    wait_hi(ctl_rsp_valid, 40);
    chk({sa_wr_en, ctl_rsp_ok, sa_wr_idx}, {2'b11, idx}, "control answer");
  endtask

  task automatic pkt(input logic cr, input logic psp, input logic ing, input logic [SA_IDX_W-1:0] idx);
    d = {$urandom, $urandom, $urandom, $urandom};
    @(posedge clk_sys);
    pkt_in_valid <= 1'b1;
    pkt_in_crypto <= cr;
    pkt_in_psp <= psp;
    pkt_in_ingress <= ing;
    pkt_in_key_256 <= $urandom;
    pkt_in_sa_idx <= idx;
    pkt_in_spi <= $urandom;
    pkt_in_iv <= {$urandom, $urandom};
    pkt_in_data <= d;
    lat <= 4'($urandom % 16);
    @(negedge clk_sys);
    wait_hi(pkt_in_ready, 40);
    @(posedge clk_sys);
    pkt_in_valid <= 1'b0;
    @(negedge clk_sys);
    wait_hi(pkt_out_valid, 80);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #200us;
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end

  // ==========
  // Main sequence
  initial begin
    {rst_n, key_wr_en, key_wr_sel, rd_en, ctl_valid, ctl_op, ctl_key_256} = '0;
    {pkt_in_valid, pkt_in_crypto, pkt_in_psp, pkt_in_ingress, pkt_in_key_256} = '0;
    {key_wr_idx, rd_addr, lat, key_wr_data, pkt_in_spi, ctl_sa_idx, pkt_in_sa_idx} = '0;
    {ctl_key, pkt_in_iv, pkt_in_data, d} = '0;
    fail_count = 0;
    total_checks = 0;
    r = $urandom(32'hdf83723c);
    for (int i = 0; i < KEY_WORDS; i++) begin
      mkey[32*i +: 32] = $urandom;
      wkey[32*i +: 32] = $urandom;
      skey[32*i +: 32] = $urandom;
    end
    do_reset();
    rd(RD_STATUS, exp_status(1'b1, 1'b0, 3'h0));
    load_keys();
    for (int a = 1; a < 16; a++) begin
      rd(4'(a), 32'h0);
    end
    $display("test status and key load done");
    ctl(CTL_OP_ADD, 10'h2a, 1'b1);
    e0 = sa_wr_data;
    chk(e0[SA_K256_B], 1'b1, "wide key flag");
    chk({e0[KW-1:0] === skey, e0[KW-1:0] === wkey, e0[KW-1:0] === mkey}, '0, "plain key out");
    ctl(CTL_OP_ADD, 10'h3ff, 1'b0);
    chk(sa_wr_data[SA_K256_B], 1'b0, "narrow key flag");
    $display("test sa add done");
    for (int k = 0; k < 30; k++) begin
      r = $urandom;
      pkt(r[0], r[1], r[2], 10'h3ff);
      chk({pkt_out_crypto, pkt_out_drop}, {r[0], 1'b0}, "service kind");
      ek = (r[1] && r[2]) ? ref_core(mkey, {KEY_WORDS{pkt_in_spi}}) : {128'h0, skey[KW/2-1:0]};
      if (r[1] && r[2] && !pkt_in_key_256) begin
        ek[KW-1:KW/2] = '0;
      end
      ks = ref_core(ek, {4{pkt_in_iv}});
      chk(pkt_out_data, r[0] ? (d ^ ks[PKT_W-1:0]) : d, "payload handling");
    end
    $display("test packets done");
    ctl(CTL_OP_DEL, 10'h2a, 1'b0);
    chk(sa_wr_data, '0, "deleted entry");
    pkt(1'b1, 1'b0, 1'b0, 10'h2a);
    chk({pkt_out_crypto, pkt_out_drop}, 2'b11, "zero entry dropped");
    $display("test sa delete done");
    do_reset();
    ctl(CTL_OP_ADD, 10'h2a, 1'b1);
    chk(sa_wr_data === e0, 1'b0, "keys cleared");
    do_reset();
    load_keys();
    ctl(CTL_OP_ADD, 10'h2a, 1'b1);
    chk(sa_wr_data, e0, "default state");
    $display("test rerun done");
    end_of_test();
  end
endmodule // testbench

//--- verilog/cks_core.sv
`timescale 1ns/1ps
module cks_core
  import cks_pkg::*;
#(
  parameter int NROUNDS = ROUNDS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Request and result
  cks_core_if.unit cif
);

  // ===========================================================================
  // Keyed round engine
  // Reduced round engine standing in for the AES datapath; one round per cycle.
  typedef struct packed {
    logic          busy;
    logic [2:0]    rnd;
    logic [KW-1:0] s;
    logic [KW-1:0] k;
    logic          done;
    logic          err;
    logic [KW-1:0] res;
  } cks_core_st_t;

  cks_core_st_t c_r, c_nxt;
  logic [KW-1:0] rnd_out;

  assign rnd_out = {c_r.s[KW-33:0], c_r.s[KW-1:KW-32]} ^ c_r.k ^ {KEY_WORDS{29'h0, c_r.rnd}};

  always_comb begin
    c_nxt      = c_r;
    c_nxt.done = 1'b0;
    c_nxt.err  = 1'b0;
    if (cif.req && !c_r.busy) begin
      if (cif.ecb && !cif.allow_ecb) begin
        c_nxt.done = 1'b1;
        c_nxt.err  = 1'b1;
        c_nxt.res  = '0;
      end else begin
        c_nxt.busy = 1'b1;
        c_nxt.rnd  = 3'h0;
        c_nxt.s    = cif.blk;
        c_nxt.k    = cif.key;
      end
    end else if (c_r.busy) begin
      c_nxt.s   = rnd_out;
      c_nxt.rnd = c_r.rnd + 3'h1;
      if (c_r.rnd == 3'(NROUNDS - 1)) begin
        c_nxt.busy = 1'b0;
        c_nxt.done = 1'b1;
        c_nxt.res  = rnd_out;
        // The working key copy is scrubbed as soon as the result leaves.
        c_nxt.k    = '0;
        c_nxt.s    = '0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign cif.done = c_r.done;
  assign cif.err  = c_r.err;
  assign cif.res  = c_r.res;

  property p_ecb_refused;
    @(posedge clk_sys) disable iff (!rst_n)
      (cif.req && !c_r.busy && cif.ecb && !cif.allow_ecb) |=> (cif.done && cif.err);
  endproperty
  a_ecb_refused: assert property (p_ecb_refused) else $error("ECB request not refused");

endmodule // cks_core

//--- verilog/cks_core_if.sv
`timescale 1ns/1ps
interface cks_core_if;
  import cks_pkg::*;
  logic          req;
  logic          ecb;
  logic          allow_ecb;
  logic [KW-1:0] key;
  logic [KW-1:0] blk;
  logic          done;
  logic          err;
  logic [KW-1:0] res;
  modport host (output req, ecb, allow_ecb, key, blk, input done, err, res);
  modport unit (input req, ecb, allow_ecb, key, blk, output done, err, res);
endinterface

//--- verilog/cks_key_store.sv
`timescale 1ns/1ps
// Summary of operation
// - Session keys are 128 or 256 bits; 128-bit keys have upper half forced zero.
// - PSP keys are derived by a counter-mode function keyed by the 256-bit master key.
// - Ingress PSP packets derive their key from the master key on demand.
// - Master and wrapping keys load as plaintext writes and never leave the block.
// - Written key registers have no readback path of any kind.
// - A 256-bit wrapping key encrypts SA keys outbound and decrypts them inbound.
// - SA creation writes the SA table only with the wrapped key.
// - Packet processing fetches wrapped SA keys and unwraps them internally.
// - Reset clears every key, secret and working copy.
// - After reset the block returns to defaults and needs keys loaded again.
// - SA delete writes an all-zero entry.
// - Power-on tests start by themselves when reset releases.
// - Five tests: ingress decrypt, key derivation, egress encrypt, wrap encrypt, wrap decrypt.
// - No packet or crypto service until every power-on test passes.
// - A failed test keeps the block uninitialised and forwarding nothing.
// - When failed, control requests are answered but not carried out.
// - A failure reports an error code and locks until reset.
// - Every reset reruns the whole test sequence.
// - Each packet gets exactly bypass or crypto, never both.
// - ECB mode is never offered while operational.
// - Metadata crypto bit chooses crypto processing or plaintext bypass per packet.
module cks_key_store
  import cks_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // Key loading
  input  wire logic                key_wr_en,
  input  wire logic                key_wr_sel,
  input  wire logic [2:0]          key_wr_idx,
  input  wire logic [31:0]         key_wr_data,
  // Status read
  input  wire logic                rd_en,
  input  wire logic [3:0]          rd_addr,
  output logic                     rd_valid,
  output logic [31:0]              rd_data,
  // Control requests
  input  wire logic                ctl_valid,
  input  wire logic                ctl_op,
  input  wire logic [SA_IDX_W-1:0] ctl_sa_idx,
  input  wire logic [KW-1:0]       ctl_key,
  input  wire logic                ctl_key_256,
  output logic                     ctl_ready,
  output logic                     ctl_rsp_valid,
  output logic                     ctl_rsp_ok,
  // SA table
  output logic                     sa_wr_en,
  output logic [SA_IDX_W-1:0]      sa_wr_idx,
  output logic [SA_W-1:0]          sa_wr_data,
  output logic                     sa_rd_en,
  output logic [SA_IDX_W-1:0]      sa_rd_idx,
  input  wire logic                sa_rd_valid,
  input  wire logic [SA_W-1:0]     sa_rd_data,
  // Packets
  input  wire logic                pkt_in_valid,
  output logic                     pkt_in_ready,
  input  wire logic                pkt_in_crypto,
  input  wire logic                pkt_in_psp,
  input  wire logic                pkt_in_ingress,
  input  wire logic                pkt_in_key_256,
  input  wire logic [SA_IDX_W-1:0] pkt_in_sa_idx,
  input  wire logic [31:0]         pkt_in_spi,
  input  wire logic [CTR_W-1:0]    pkt_in_iv,
  input  wire logic [PKT_W-1:0]    pkt_in_data,
  output logic                     pkt_out_valid,
  output logic                     pkt_out_crypto,
  output logic                     pkt_out_drop,
  output logic [PKT_W-1:0]         pkt_out_data,
  // Status
  output logic                     st_ready,
  output logic                     st_fail,
  output logic [2:0]               st_err_code
);

  // ===========================================================================
  // State
  typedef struct packed {
    cks_state_t          state;
    logic [KW-1:0]       master;
    logic [KW-1:0]       wrap;
    logic [CTR_W-1:0]    add_ctr;
    logic [2:0]          kat_idx;
    logic                turn;
    logic                use_sa;
    logic                k256;
    logic                sa_empty;
    logic [KW-1:0]       work;
    logic [CTR_W-1:0]    iv;
    logic [PKT_W-1:0]    data;
    logic [KW-1:0]       ckey;
    logic                ck256;
    logic [SA_IDX_W-1:0] cidx;
    logic                ctl_rdy;
    logic                rsp_v;
    logic                rsp_ok;
    logic                pkt_rdy;
    logic                sa_wr;
    logic [SA_IDX_W-1:0] sa_widx;
    logic [SA_W-1:0]     sa_wdata;
    logic                sa_rd;
    logic [SA_IDX_W-1:0] sa_ridx;
    logic                out_v;
    logic                out_crypto;
    logic                out_drop;
    logic [PKT_W-1:0]    out_data;
    logic                rd_v;
    logic [31:0]         rd_d;
    logic                st_rdy;
    logic                st_fl;
    logic [2:0]          err;
    logic                c_req;
    logic [KW-1:0]       c_key;
    logic [KW-1:0]       c_blk;
  } cks_top_st_t;

  cks_top_st_t s_r, s_nxt;
  cks_core_if  cif ();

  cks_core #(.NROUNDS(ROUNDS)) u_core (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .cif     (cif.unit)
  );

  // ECB is reachable only while the tests run and is never requested here.
  assign cif.req       = s_r.c_req;
  assign cif.ecb       = 1'b0;
  assign cif.allow_ecb = (s_r.state == S_KAT_GO) || (s_r.state == S_KAT_WAIT);
  assign cif.key       = s_r.c_key;
  assign cif.blk       = s_r.c_blk;

  function automatic logic [KW-1:0] key_mask(input logic [KW-1:0] k, input logic is256);
    return is256 ? k : {{(KW/2){1'b0}}, k[KW/2-1:0]};
  endfunction

  // ===========================================================================
  // Next state
  logic          ctl_take;
  logic          pkt_take;
  logic [KW-1:0] kres;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.rsp_v = 1'b0;
    s_nxt.sa_wr = 1'b0;
    s_nxt.sa_rd = 1'b0;
    s_nxt.out_v = 1'b0;
    s_nxt.rd_v  = 1'b0;
    s_nxt.c_req = 1'b0;
    s_nxt.turn  = ~s_r.turn;
    ctl_take    = ctl_valid && s_r.ctl_rdy;
    pkt_take    = pkt_in_valid && s_r.pkt_rdy;
    kres        = key_mask(s_r.use_sa ? (cif.res ^ s_r.work) : cif.res, s_r.k256);

    // Key words only land while operational; no path leads back out.
    if (key_wr_en && s_r.st_rdy) begin
      if (key_wr_sel == KSEL_MASTER) begin
        s_nxt.master[32*key_wr_idx +: 32] = key_wr_data;
      end else begin
        s_nxt.wrap[32*key_wr_idx +: 32] = key_wr_data;
      end
    end
    if (rd_en) begin
      s_nxt.rd_v = 1'b1;
      s_nxt.rd_d = (rd_addr == RD_STATUS) ? 32'({s_r.err, s_r.st_fl, s_r.st_rdy}) : 32'h0;
    end

    unique case (s_r.state)
      S_KAT_GO: begin
        s_nxt.c_req = 1'b1;
        s_nxt.c_key = kat_key(s_r.kat_idx);
        s_nxt.c_blk = {KEY_WORDS{KAT_BLK_W}};
        s_nxt.state = S_KAT_WAIT;
      end
      S_KAT_WAIT: begin
        if (cif.done) begin
          if (cif.err || cif.res != kat_exp(s_r.kat_idx)) begin
            s_nxt.st_fl = 1'b1;
            s_nxt.err   = s_r.kat_idx + 3'h1;
            s_nxt.state = S_FAIL;
          end else if (s_r.kat_idx == KAT_NUM - 3'h1) begin
            s_nxt.st_rdy = 1'b1;
            s_nxt.state  = S_IDLE;
          end else begin
            s_nxt.kat_idx = s_r.kat_idx + 3'h1;
            s_nxt.state   = S_KAT_GO;
          end
        end
      end
      S_IDLE: begin
        if (ctl_take && ctl_op == CTL_OP_DEL) begin
          s_nxt.sa_wr    = 1'b1;
          s_nxt.sa_widx  = ctl_sa_idx;
          s_nxt.sa_wdata = '0;
          s_nxt.rsp_v    = 1'b1;
          s_nxt.rsp_ok   = 1'b1;
        end else if (ctl_take) begin
          s_nxt.ckey  = key_mask(ctl_key, ctl_key_256);
          s_nxt.ck256 = ctl_key_256;
          s_nxt.cidx  = ctl_sa_idx;
          s_nxt.c_req = 1'b1;
          s_nxt.c_key = s_r.wrap;
          s_nxt.c_blk = {4{s_r.add_ctr}};
          s_nxt.state = S_WRAP;
        end else if (pkt_take && !pkt_in_crypto) begin
          s_nxt.out_v      = 1'b1;
          s_nxt.out_crypto = 1'b0;
          s_nxt.out_drop   = 1'b0;
          s_nxt.out_data   = pkt_in_data;
        end else if (pkt_take) begin
          s_nxt.data     = pkt_in_data;
          s_nxt.iv       = pkt_in_iv;
          s_nxt.sa_empty = 1'b0;
          if (pkt_in_psp && pkt_in_ingress) begin
            s_nxt.use_sa = 1'b0;
            s_nxt.k256   = pkt_in_key_256;
            s_nxt.c_req  = 1'b1;
            s_nxt.c_key  = s_r.master;
            s_nxt.c_blk  = {KEY_WORDS{pkt_in_spi}};
            s_nxt.state  = S_KEY;
          end else begin
            s_nxt.use_sa  = 1'b1;
            s_nxt.sa_rd   = 1'b1;
            s_nxt.sa_ridx = pkt_in_sa_idx;
            s_nxt.state   = S_FETCH;
          end
        end
      end
      S_WRAP: begin
        if (cif.done) begin
          s_nxt.sa_wr    = 1'b1;
          s_nxt.sa_widx  = s_r.cidx;
          s_nxt.sa_wdata = {s_r.add_ctr, s_r.ck256, s_r.ckey ^ cif.res};
          s_nxt.add_ctr  = s_r.add_ctr + 64'h1;
          s_nxt.ckey     = '0;
          s_nxt.rsp_v    = 1'b1;
          s_nxt.rsp_ok   = 1'b1;
          s_nxt.state    = S_IDLE;
        end
      end
      S_FETCH: begin
        if (sa_rd_valid) begin
          // A deleted entry reads all zero; its packets are marked for drop.
          s_nxt.sa_empty = (sa_rd_data == '0);
          s_nxt.k256     = sa_rd_data[SA_K256_B];
          s_nxt.work     = sa_rd_data[KW-1:0];
          s_nxt.c_req    = 1'b1;
          s_nxt.c_key    = s_r.wrap;
          s_nxt.c_blk    = {4{sa_rd_data[SA_CTR_LSB +: CTR_W]}};
          s_nxt.state    = S_KEY;
        end
      end
      S_KEY: begin
        if (cif.done) begin
          s_nxt.work  = kres;
          s_nxt.c_req = 1'b1;
          s_nxt.c_key = kres;
          s_nxt.c_blk = {4{s_r.iv}};
          s_nxt.state = S_DATA;
        end
      end
      S_DATA: begin
        if (cif.done) begin
          s_nxt.out_v      = 1'b1;
          s_nxt.out_crypto = 1'b1;
          s_nxt.out_drop   = s_r.sa_empty || cif.err;
          s_nxt.out_data   = s_r.data ^ cif.res[PKT_W-1:0];
          s_nxt.work       = '0;
          s_nxt.c_key      = '0;
          s_nxt.state      = S_IDLE;
        end
      end
      S_FAIL: begin
        if (ctl_take) begin
          s_nxt.rsp_v  = 1'b1;
          s_nxt.rsp_ok = 1'b0;
        end
      end
    endcase

    s_nxt.ctl_rdy = (s_nxt.state == S_IDLE && s_nxt.turn) || s_nxt.state == S_FAIL;
    s_nxt.pkt_rdy = (s_nxt.state == S_IDLE) && !s_nxt.turn;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ===========================================================================
  // Outputs
  assign rd_valid       = s_r.rd_v;
  assign rd_data        = s_r.rd_d;
  assign ctl_ready      = s_r.ctl_rdy;
  assign ctl_rsp_valid  = s_r.rsp_v;
  assign ctl_rsp_ok     = s_r.rsp_ok;
  assign sa_wr_en       = s_r.sa_wr;
  assign sa_wr_idx      = s_r.sa_widx;
  assign sa_wr_data     = s_r.sa_wdata;
  assign sa_rd_en       = s_r.sa_rd;
  assign sa_rd_idx      = s_r.sa_ridx;
  assign pkt_in_ready   = s_r.pkt_rdy;
  assign pkt_out_valid  = s_r.out_v;
  assign pkt_out_crypto = s_r.out_crypto;
  assign pkt_out_drop   = s_r.out_drop;
  assign pkt_out_data   = s_r.out_data;
  assign st_ready       = s_r.st_rdy;
  assign st_fail        = s_r.st_fl;
  assign st_err_code    = s_r.err;

  // ===========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_kat_quiet;
    !st_ready |-> (!pkt_out_valid && !pkt_in_ready && !sa_wr_en && !sa_rd_en);
  endproperty
  a_kat_quiet: assert property (p_kat_quiet) else $error("Service before tests passed");

  property p_kat_no_ctl;
    (!st_ready && !st_fail) |-> !ctl_ready;
  endproperty
  a_kat_no_ctl: assert property (p_kat_no_ctl) else $error("Control taken during tests");

  property p_key_rd_zero;
    (rd_en && rd_addr != RD_STATUS) |=> (rd_valid && rd_data == 32'h0);
  endproperty
  a_key_rd_zero: assert property (p_key_rd_zero) else $error("Key location read nonzero");

  property p_del_zero;
    (ctl_valid && ctl_ready && ctl_op == CTL_OP_DEL && st_ready)
      |=> (sa_wr_en && sa_wr_data == '0 && sa_wr_idx == $past(ctl_sa_idx) && ctl_rsp_ok);
  endproperty
  a_del_zero: assert property (p_del_zero) else $error("Delete did not zero entry");

  property p_bypass;
    (pkt_in_valid && pkt_in_ready && !pkt_in_crypto)
      |=> (pkt_out_valid && !pkt_out_crypto && !pkt_out_drop && pkt_out_data == $past(pkt_in_data));
  endproperty
  a_bypass: assert property (p_bypass) else $error("Bypass packet altered");

  property p_fail_lock;
    st_fail |=> (st_fail && !st_ready && st_err_code == $past(st_err_code) && st_err_code != 3'h0);
  endproperty
  a_fail_lock: assert property (p_fail_lock) else $error("Failure lock released");

  property p_fail_answer;
    (st_fail && ctl_valid && ctl_ready) |=> (ctl_rsp_valid && !ctl_rsp_ok && !sa_wr_en);
  endproperty
  a_fail_answer: assert property (p_fail_answer) else $error("Failed state executed request");

  property p_add_wrapped;
    (ctl_valid && ctl_ready && ctl_op == CTL_OP_ADD && st_ready)
      |=> !sa_wr_en [*5] ##1 !sa_wr_en ##[1:3] (sa_wr_en && sa_wr_data[SA_K256_B] == $past(s_r.ck256));
  endproperty
  a_add_wrapped: assert property (p_add_wrapped) else $error("SA add write timing wrong");

  property p_kat_start;
    $rose(rst_n) |-> (s_r.state == S_KAT_GO && !st_ready);
  endproperty
  a_kat_start: assert property (@(posedge clk_sys) p_kat_start) else $error("Tests did not start");

  property p_ecb_locked;
    st_ready |-> !cif.allow_ecb;
  endproperty
  a_ecb_locked: assert property (p_ecb_locked) else $error("ECB reachable while operational");

endmodule // cks_key_store

//--- verilog/cks_pkg.sv
package cks_pkg;

  // ===========================================================================
  // Widths and SA entry layout
  localparam int KW         = 256;
  localparam int KEY_WORDS  = 8;
  localparam int CTR_W      = 64;
  localparam int SA_IDX_W   = 10;
  localparam int PKT_W      = 128;
  localparam int SA_K256_B  = KW;
  localparam int SA_CTR_LSB = KW + 1;
  localparam int SA_W       = KW + 1 + CTR_W;

  // ===========================================================================
  // Key select, control opcodes, status read map
  localparam logic       KSEL_MASTER = 1'b0;
  localparam logic       KSEL_WRAP   = 1'b1;
  localparam logic       CTL_OP_ADD  = 1'b0;
  localparam logic       CTL_OP_DEL  = 1'b1;
  localparam logic [3:0] RD_STATUS   = 4'h0;

  // ===========================================================================
  // Cipher core and power-on test vectors
  localparam int          ROUNDS     = 5;
  localparam logic [2:0]  KAT_NUM    = 3'h5;
  localparam logic [31:0] KAT_KEY_W  = 32'h3c5a_96e1;
  localparam logic [31:0] KAT_BLK_W  = 32'h0f1e_2d3c;
  localparam logic [31:0] KAT_RC_XOR = 32'h0000_0004;

  typedef enum logic [3:0] {
    S_KAT_GO, S_KAT_WAIT, S_IDLE, S_WRAP, S_FETCH, S_KEY, S_DATA, S_FAIL
  } cks_state_t;

  // Test 0 ingress decrypt, 1 key derivation, 2 egress encrypt, 3/4 SA wrap enc/dec.
  function automatic logic [KW-1:0] kat_key(input logic [2:0] idx);
    return {KEY_WORDS{KAT_KEY_W ^ {29'h0, idx}}};
  endfunction

  function automatic logic [KW-1:0] kat_exp(input logic [2:0] idx);
    return {KEY_WORDS{KAT_BLK_W ^ KAT_KEY_W ^ {29'h0, idx} ^ KAT_RC_XOR}};
  endfunction

endpackage
